/* File: logic/srs_regs.vh */
// register offsets, field positions and timing constants for the shadow register bank
`ifndef SRS_REGS_VH
`define SRS_REGS_VH

`define SRS_ADDR_AMC        16'hb072
`define SRS_ADDR_SPM        16'hd072
`define SRS_ADDR_ICM        16'hd472
`define SRS_ADDR_CAM        16'he472
`define SRS_ADDR_RTC        16'h0070

`define SRS_AMC_REQUEST_ACTIVITY_ENABLE_BIT   15
`define SRS_AMC_TAP_BIT     14
`define SRS_AMC_RESET       16'h0000
`define SRS_TIME_OF_DAY_STALE_BIT       11
`define SRS_TIME_OF_DAY_STALE_RESET     1'b0

`define SRS_OCW2_ROT_AEOI   3'b100
`define SRS_OCW3_SMM_SET    2'b11

// quiet time after the last dma cycle, in nanoseconds
`define SRS_QUIET_NS        30500
`define SRS_CLK_NS          40
`define SRS_QUIET_CYCLES    ((`SRS_QUIET_NS + `SRS_CLK_NS - 1) / `SRS_CLK_NS)

`endif

/* File: logic/srs_sync.v */
// two-flop synchroniser for a single asynchronous level
`timescale 1ns/1ns
module srs_sync (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire d_i,
	output wire q_o
);
	reg meta_q;
	reg sync_q;

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule

/* File: logic/srs_quiet_timer.v */
// counts clocks since the last dma cycle and flags the quiet state
`timescale 1ns/1ns
`include "srs_regs.vh"
module srs_quiet_timer (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire busy_i,
	output wire quiet_o
);
	// the full-width count is cut on purpose; it stays well under 1024
	localparam [31:0] LIMIT_FULL = `SRS_QUIET_CYCLES;
	localparam [9:0]  LIMIT      = LIMIT_FULL[9:0];

	reg [9:0] cnt_q;
	reg       quiet_q;

	// a new cycle restarts the count and drops the flag at once
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q   <= 10'h000;
			quiet_q <= 1'b0;
		end else if (busy_i) begin
			cnt_q   <= 10'h000;
			quiet_q <= 1'b0;
		end else if (cnt_q != LIMIT) begin
			cnt_q   <= cnt_q + 10'h001;
			quiet_q <= 1'b0;
		end else begin
			quiet_q <= 1'b1;
		end
	end

	assign quiet_o = quiet_q;
endmodule

/* File: logic/srs_shadow_bank.v */
// suspend/resume shadow register bank: mirrors write-only state for readback
`timescale 1ns/1ns
`include "srs_regs.vh"

//////////////////////////////////////////////////////////////////////////////
// Function
// - serial A/B reg2 bits 7:6 at 15:12
// - parallel reg2 bits 3:0 at 11:8
// - parallel reg0 byte at bits 7:0
// - timeout comparator output at bit 15
// - fixed device id field at 14:13
// - master/slave vector bit 7 at 12/11
// - master special fully nested at bit 10
// - master automatic end of irq at 9
// - master rotate-on-auto-eoi selection at bit 8
// - master lowest priority at bits 7:5
// - slave lowest priority at bits 4:2
// - special mask mode master/slave at 1/0
// - port-70 mirror readable while locked
// - bit 15 is refresh reference halved
// - bit 14 copies refresh detect bit
// - bit 13 shows processor interrupt request
// - bit 12 quiet after 30.5us without dma
// - storage bit 11, written only unlocked
// - bits 10:8 reserved, read zero
// - port 70 write captures mask, index
// - bit 15 enables irq bits as activity
// - bit 14 shows timeout counter bit 12
module srs_shadow_bank #(
	parameter [1:0] DEVICE_ID = 2'b01 // arbitrary neutral value
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [15:0] io_addr_i,
	input  wire [15:0] io_wdata_i,
	input  wire        io_wr_i,
	input  wire        io_rd_i,
	input  wire        unlocked_i,
	input  wire        serial_a_wr_i,
	input  wire        serial_b_wr_i,
	input  wire        parallel_reg2_wr_i,
	input  wire        parallel_reg0_wr_i,
	input  wire        master_icw2_wr_i,
	input  wire        slave_icw2_wr_i,
	input  wire        master_icw4_wr_i,
	input  wire        master_ocw2_wr_i,
	input  wire        slave_ocw2_wr_i,
	input  wire        master_ocw3_wr_i,
	input  wire        slave_ocw3_wr_i,
	input  wire [7:0]  port_wdata_i,
	input  wire        timeout_comparator_state_i,
	input  wire        timeout_counter_tap_i,
	input  wire        refresh_reference_input_i,
	input  wire        refresh_toggle_copy_i,
	input  wire        cpu_intr_i,
	input  wire        dma_cycle_i,
	input  wire        irq_activity_i,
	output reg  [15:0] io_rdata_o,
	output wire        io_hit_o,
	output wire        request_activity_enable_o,
	output wire        irq_activity_o
);
	//////////////////////////////////////////////////////////////////////////
	// address decode
	function is_addr;
		input [15:0] a;
		input [15:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	wire hit_amc = is_addr(io_addr_i, `SRS_ADDR_AMC);
	wire hit_spm = is_addr(io_addr_i, `SRS_ADDR_SPM);
	wire hit_icm = is_addr(io_addr_i, `SRS_ADDR_ICM);
	wire hit_cam = is_addr(io_addr_i, `SRS_ADDR_CAM);
	wire hit_rtc = is_addr(io_addr_i, `SRS_ADDR_RTC);

	assign io_hit_o = hit_amc | hit_spm | hit_icm | hit_cam;

	//////////////////////////////////////////////////////////////////////////
	// pins from other clock domains
	wire ref_s;
	wire intr_s;
	wire dma_s;

	srs_sync u_sync_ref (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (refresh_reference_input_i),
		.q_o     (ref_s)
	);

	srs_sync u_sync_intr (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (cpu_intr_i),
		.q_o     (intr_s)
	);

	srs_sync u_sync_dma (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (dma_cycle_i),
		.q_o     (dma_s)
	);

	//////////////////////////////////////////////////////////////////////////
	// serial and parallel mirror
	reg [1:0] serial_a_high_bits_q;
	reg [1:0] serial_b_high_bits_q;
	reg [3:0] parallel_reg2_low_bits_q;
	reg [7:0] parallel_reg0_copy_q;

	// no reset: mirror values have no defined power-up state; they follow
	// every write of the source so a read reflects the latest write
	always @(posedge clk_i) begin
		if (serial_a_wr_i)
			serial_a_high_bits_q <= port_wdata_i[7:6];
		if (serial_b_wr_i)
			serial_b_high_bits_q <= port_wdata_i[7:6];
		if (parallel_reg2_wr_i)
			parallel_reg2_low_bits_q <= port_wdata_i[3:0];
		if (parallel_reg0_wr_i)
			parallel_reg0_copy_q <= port_wdata_i;
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt controller mirror
	reg       master_vector_bit7_q;
	reg       slave_vector_bit7_q;
	reg       fully_nested_special_q;
	reg       automatic_end_of_irq_q;
	reg       rotate_auto_end_of_irq_q;
	reg [2:0] master_lowest_priority_q;
	reg [2:0] slave_lowest_priority_q;
	reg       master_special_masking_q;
	reg       slave_special_masking_q;

	wire [2:0] end_of_irq_command_field = port_wdata_i[7:5];
	wire [2:0] priority_level_field     = port_wdata_i[2:0];
	// ocw2 commands that carry a level: specific eoi, rotate specific, set priority
	wire       ocw2_has_level = end_of_irq_command_field[1];
	// ocw2 codes 100/000 set or clear rotate-on-auto-eoi; others leave it
	wire       ocw2_rot_cmd = (end_of_irq_command_field[1:0] == 2'b00);

	always @(posedge clk_i) begin
		if (master_icw2_wr_i)
			master_vector_bit7_q <= port_wdata_i[7];
		if (slave_icw2_wr_i)
			slave_vector_bit7_q <= port_wdata_i[7];
		if (master_icw4_wr_i) begin
			fully_nested_special_q <= port_wdata_i[4];
			automatic_end_of_irq_q <= port_wdata_i[1];
		end
		if (master_ocw2_wr_i && ocw2_rot_cmd)
			rotate_auto_end_of_irq_q <=
				(end_of_irq_command_field == `SRS_OCW2_ROT_AEOI);
		if (master_ocw2_wr_i && ocw2_has_level)
			master_lowest_priority_q <= priority_level_field;
		if (slave_ocw2_wr_i && ocw2_has_level)
			slave_lowest_priority_q <= priority_level_field;
		// ocw3 bit 6 is the action enable; bit 5 sets or clears the mode
		if (master_ocw3_wr_i && port_wdata_i[6])
			master_special_masking_q <= port_wdata_i[5];
		if (slave_ocw3_wr_i && port_wdata_i[6])
			slave_special_masking_q <= port_wdata_i[5];
	end

	//////////////////////////////////////////////////////////////////////////
	// port-70 mirror and status
	reg       half_refresh_ref_tick_q;
	reg       ref_prev_q;
	reg       time_of_day_stale_q;
	reg       nonmaskable_mask_copy_q;
	reg [6:0] clock_ram_index_copy_q;
	wire      dma_quiet_flag;

	srs_quiet_timer u_quiet (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.busy_i  (dma_s),
		.quiet_o (dma_quiet_flag)
	);

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			half_refresh_ref_tick_q <= 1'b0;
			ref_prev_q              <= 1'b0;
			time_of_day_stale_q     <= `SRS_TIME_OF_DAY_STALE_RESET;
		end else begin
			ref_prev_q <= ref_s;
			// toggling on each rising edge halves the reference rate
			if (ref_s && !ref_prev_q)
				half_refresh_ref_tick_q <= ~half_refresh_ref_tick_q;
			if (io_wr_i && hit_cam && unlocked_i)
				time_of_day_stale_q <= io_wdata_i[`SRS_TIME_OF_DAY_STALE_BIT];
		end
	end

	always @(posedge clk_i) begin
		if (io_wr_i && hit_rtc) begin
			nonmaskable_mask_copy_q <= io_wdata_i[7];
			clock_ram_index_copy_q  <= io_wdata_i[6:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// activity monitor control, upper bits
	reg         request_activity_enable_q;
	wire [15:0] amc_reset_word = `SRS_AMC_RESET;

	always @(posedge clk_i) begin
		if (!rst_n_i)
			request_activity_enable_q <= amc_reset_word[`SRS_AMC_REQUEST_ACTIVITY_ENABLE_BIT];
		else if (io_wr_i && hit_amc && unlocked_i)
			request_activity_enable_q <= io_wdata_i[`SRS_AMC_REQUEST_ACTIVITY_ENABLE_BIT];
	end

	assign request_activity_enable_o = request_activity_enable_q;
	assign irq_activity_o = irq_activity_i & request_activity_enable_q;

	//////////////////////////////////////////////////////////////////////////
	// read mux; registered data output, only the ports above decode
	wire [15:0] spm_word = {serial_a_high_bits_q, serial_b_high_bits_q,
		parallel_reg2_low_bits_q, parallel_reg0_copy_q};
	wire [15:0] icm_word = {timeout_comparator_state_i, DEVICE_ID,
		master_vector_bit7_q, slave_vector_bit7_q, fully_nested_special_q,
		automatic_end_of_irq_q, rotate_auto_end_of_irq_q,
		master_lowest_priority_q, slave_lowest_priority_q,
		master_special_masking_q, slave_special_masking_q};
	wire [15:0] cam_word = {half_refresh_ref_tick_q, refresh_toggle_copy_i,
		intr_s, dma_quiet_flag, time_of_day_stale_q, 3'b000,
		nonmaskable_mask_copy_q, clock_ram_index_copy_q};
	wire [15:0] amc_word = {request_activity_enable_q, timeout_counter_tap_i,
		14'h0000};

	always @(posedge clk_i) begin
		if (!rst_n_i)
			io_rdata_o <= 16'h0000;
		else if (io_rd_i) begin
			// the port-70 mirror ignores the lock state
			if (hit_cam)
				io_rdata_o <= cam_word;
			else if (hit_spm)
				io_rdata_o <= spm_word;
			else if (hit_icm)
				io_rdata_o <= icm_word;
			else if (hit_amc)
				io_rdata_o <= amc_word;
			else
				io_rdata_o <= 16'h0000;
		end
	end
endmodule

/* File: testbench/srs_shadow_bank_asserts.sv */
// concurrent checks on the shadow register bank ports
`timescale 1ns/1ns
`include "srs_regs.vh"
module srs_shadow_bank_asserts #(
	parameter [1:0] DEVICE_ID = 2'h1
) (
	input wire        clk_i,
	input wire        rst_n_i,
	input wire [15:0] io_addr_i,
	input wire [15:0] io_wdata_i,
	input wire        io_wr_i,
	input wire        io_rd_i,
	input wire        unlocked_i,
	input wire        timeout_comparator_state_i,
	input wire        timeout_counter_tap_i,
	input wire        refresh_toggle_copy_i,
	input wire        irq_activity_i,
	input wire [15:0] io_rdata_o,
	input wire        request_activity_enable_o,
	input wire        irq_activity_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence rd_s(a);
		io_rd_i && io_addr_i == a;
	endsequence
	sequence wr_amc_s;
		io_wr_i && io_addr_i == `SRS_ADDR_AMC;
	endsequence
	timeout_comparator_state_seen_a: assert property (rd_s(`SRS_ADDR_ICM) |=>
		io_rdata_o[15] == $past(timeout_comparator_state_i)) else $error("comparator bit wrong");
	dev_id_a: assert property (rd_s(`SRS_ADDR_ICM) |=> io_rdata_o[14:13] == DEVICE_ID)
		else $error("device id field wrong");
	refresh_toggle_copy_copy_a: assert property (rd_s(`SRS_ADDR_CAM) |=>
		io_rdata_o[14] == $past(refresh_toggle_copy_i)) else $error("refresh copy wrong");
	rsvd_zero_a: assert property (rd_s(`SRS_ADDR_CAM) |=> io_rdata_o[10:8] == 3'h0)
		else $error("reserved bits not zero");
	tap_copy_a: assert property (rd_s(`SRS_ADDR_AMC) |=>
		io_rdata_o[14] == $past(timeout_counter_tap_i)) else $error("counter tap wrong");
	rae_locked_a: assert property (wr_amc_s ##0 !unlocked_i |=>
		$stable(request_activity_enable_o)) else $error("enable changed while locked");
	rae_write_a: assert property (wr_amc_s ##0 unlocked_i |=>
		request_activity_enable_o == $past(io_wdata_i[15])) else $error("enable not written");
	irq_gate_a: assert property (irq_activity_o == (irq_activity_i &&
		request_activity_enable_o)) else $error("irq activity gate wrong");
endmodule
bind srs_shadow_bank srs_shadow_bank_asserts #(.DEVICE_ID(DEVICE_ID)) i_srs_shadow_bank_asserts (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
	.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .unlocked_i(unlocked_i),
	.timeout_comparator_state_i(timeout_comparator_state_i),
	.timeout_counter_tap_i(timeout_counter_tap_i),
	.refresh_toggle_copy_i(refresh_toggle_copy_i), .irq_activity_i(irq_activity_i),
	.io_rdata_o(io_rdata_o), .request_activity_enable_o(request_activity_enable_o),
	.irq_activity_o(irq_activity_o));

/* File: testbench/tb_suspend_resume_shadow_regs.sv */
// self-checking bench for the shadow register bank
`timescale 1ns/1ns
module tb_suspend_resume_shadow_regs;
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, unl = 0, tcs = 0, tap = 0;
	logic        rfi = 0, rfd = 0, intr = 0, dma = 1, irqa = 0, hit, rae, irqo;
	logic [15:0] addr = 16'h0000, wd = 16'h0000, rdata, r0, r1;
	logic [10:0] st = 11'h000;
	logic [7:0]  pw = 8'h00;
	logic [2:0]  rc = 3'h0;
	int          num_errors = 0, comparisons = 0;
	logic [7:0]  sp [2][4] = '{'{8'hc0, 8'h40, 8'h0a, 8'h5a}, '{8'h40, 8'h80, 8'hf5, 8'ha5}};
	logic [15:0] spx [2] = '{16'hda5a, 16'h65a5};
	logic [7:0]  ic [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h12, 8'h80, 8'hc3,
		8'h68, 8'h48};
	always #20 clk = ~clk;
	// reference pin with a 16-clock period, far slower than the synchroniser
	always @(posedge clk) begin
		rc <= rc + 3'h1;
		rfi <= rfi ^ (rc == 3'h7);
	end
	srs_shadow_bank #(.DEVICE_ID(2'h2)) i_srs_shadow_bank (
		.clk_i(clk), .rst_n_i(rst_n), .io_addr_i(addr), .io_wdata_i(wd), .io_wr_i(wr),
		.io_rd_i(rd), .unlocked_i(unl), .serial_a_wr_i(st[0]), .serial_b_wr_i(st[1]),
		.parallel_reg2_wr_i(st[2]), .parallel_reg0_wr_i(st[3]), .master_icw2_wr_i(st[4]),
		.slave_icw2_wr_i(st[5]), .master_icw4_wr_i(st[6]), .master_ocw2_wr_i(st[7]),
		.slave_ocw2_wr_i(st[8]), .master_ocw3_wr_i(st[9]), .slave_ocw3_wr_i(st[10]),
		.port_wdata_i(pw), .timeout_comparator_state_i(tcs), .timeout_counter_tap_i(tap),
		.refresh_reference_input_i(rfi), .refresh_toggle_copy_i(rfd), .cpu_intr_i(intr),
		.dma_cycle_i(dma), .irq_activity_i(irqa), .io_rdata_o(rdata), .io_hit_o(hit),
		.request_activity_enable_o(rae), .irq_activity_o(irqo));
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrt(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdt(input logic [15:0] a, output logic [15:0] r);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 r = rdata;
	endtask
	task automatic strb(input int i, input logic [7:0] b);
		@(posedge clk);
		st <= 11'h001 << i;
		pw <= b;
		@(posedge clk);
		st <= 11'h000;
	endtask
	task automatic stop_test;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4000) @(posedge clk);
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 4; i++)
				strb(i, sp[k][i]);
			wrt(16'hd072, 16'hffff);
			rdt(16'hd072, r0);
			chk(r0, spx[k]);
		end
		tcs <= 1'b1;
		for (int i = 4; i < 11; i++)
			strb(i, ic[i]);
		strb(7, 8'hc5);
		wrt(16'hd472, 16'hffff);
		rdt(16'hd472, r0);
		chk(r0, 16'hd7ae);
		tcs <= 1'b0;
		strb(6, 8'h00);
		strb(7, 8'h00);
		rdt(16'hd472, r0);
		chk(r0, 16'h50ae);
		rfd <= 1'b1;
		intr <= 1'b1;
		wrt(16'h0070, 16'h00c5);
		wrt(16'he472, 16'h0800);
		wrt(16'h1234, 16'hffff);
		chk(16'(hit), 16'h0000);
		rdt(16'h1234, r0);
		chk(r0, 16'h0000);
		rdt(16'he472, r0);
		chk(16'(hit), 16'h0001);
		chk(r0 & 16'h7fff, 16'h60c5);
		unl <= 1'b1;
		wrt(16'h0070, 16'h003a);
		wrt(16'he472, 16'h08ff);
		rdt(16'he472, r0);
		chk(r0 & 16'h7fff, 16'h683a);
		rdt(16'he472, r0);
		repeat (14) @(posedge clk);
		rdt(16'he472, r1);
		chk(16'(r0[15] ^ r1[15]), 16'h0001);
		dma <= 1'b0;
		repeat (700) @(posedge clk);
		rdt(16'he472, r0);
		chk(16'(r0[12]), 16'h0000);
		repeat (100) @(posedge clk);
		rdt(16'he472, r0);
		chk(16'(r0[12]), 16'h0001);
		dma <= 1'b1;
		repeat (5) @(posedge clk);
		rdt(16'he472, r0);
		chk(16'(r0[12]), 16'h0000);
		unl <= 1'b0;
		tap <= 1'b1;
		irqa <= 1'b1;
		wrt(16'hb072, 16'h8000);
		rdt(16'hb072, r0);
		chk(r0, 16'h4000);
		chk(16'({rae, irqo}), 16'h0000);
		unl <= 1'b1;
		wrt(16'hb072, 16'h8000);
		rdt(16'hb072, r0);
		chk(r0, 16'hc000);
		chk(16'({rae, irqo}), 16'h0003);
		stop_test;
	end
endmodule
